// [include/rsim_pkg.sv]
// Constants and carrier types for the regulator status and interrupt mask registers.
// Assumes one 100 MHz clock and a byte-wide register port driven by the serial interface logic.
package rsim_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_TOP_STAT = 8'h1D;
    localparam logic [7:0] ADDR_LINREG_STAT = 8'h1F;
    localparam logic [7:0] ADDR_MASK_PRI = 8'h20;
    localparam logic [7:0] ADDR_MASK_SEC = 8'h21;

    // Linear regulator status field positions.
    localparam int LDO_B_ON = 7;
    localparam int LDO_B_VINV = 6;
    localparam int LDO_B_ILIM = 4;
    localparam int LDO_A_ON = 3;
    localparam int LDO_A_VINV = 2;
    localparam int LDO_A_ILIM = 0;

    // Top-level status field positions.
    localparam int TOP_PG = 7;
    localparam int TOP_SYNC = 4;
    localparam int TOP_TSD = 3;
    localparam int TOP_TWARN = 2;
    localparam int TOP_OVP = 1;

    // Mask and flag positions, shared by mask and flag registers.
    localparam int EVT_PG = 7;
    localparam int EVT_SYNC = 4;
    localparam int EVT_TWARN = 2;
    localparam int EVT_MEAS = 0;

    // Reset values and writable-bit masks.
    localparam logic [7:0] MASK_PRI_RST = 8'h91;
    localparam logic [7:0] MASK_PRI_WR = 8'h95;
    localparam logic [7:0] MASK_SEC_RST = 8'h01;
    localparam logic [7:0] FLAG_BITS = 8'h95;

    typedef struct packed {
        logic enabled;
        logic vout_invalid;
        logic current_limited;
    } rsim_ldo_s;

    typedef struct packed {
        logic power_good_pin;
        logic ext_clk_invalid;
        logic thermal_shutdown;
        logic thermal_warning;
        logic input_ovp;
    } rsim_top_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } rsim_bus_s;

endpackage

// [rtl/rsim_evt_detect.sv]
// Change detector for a vector of live levels.
// Assumes levels synchronous to the clock; no event is reported in the first cycle after reset.
`timescale 1ns/10ps
module rsim_evt_detect #(
    parameter int W = 4
) (
    input wire logic sys_clk_in, // System clock.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire logic [W-1:0] level_in, // Live levels.
    output logic [W-1:0] rise_out, // Rising edge seen this cycle.
    output logic [W-1:0] fall_out // Falling edge seen this cycle.
);
    logic [W-1:0] prev_q;
    logic armed_q;

    // The history is not trusted until one sample after reset, so a level that is
    // already high at release does not look like a fresh event.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            prev_q <= '0;
        end else begin
            prev_q <= level_in;
        end
    end

    assign rise_out = armed_q ? (level_in & ~prev_q) : '0;
    assign fall_out = armed_q ? (~level_in & prev_q) : '0;
endmodule

// [rtl/rsim_flag_bank.sv]
// Bank of sticky interrupt flags with write-one-to-clear.
// Assumes set pulses and clear bits are both synchronous to the clock.
`timescale 1ns/10ps
module rsim_flag_bank #(
    parameter int W = 8
) (
    input wire logic sys_clk_in, // System clock.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire logic [W-1:0] set_in, // Event pulses.
    input wire logic [W-1:0] clr_in, // Clear strobes, one per bit.
    output logic [W-1:0] flags_out // Latched flags.
);
    logic [W-1:0] flags_q;

    // A set arriving with its clear wins, so no event is lost.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_in) | set_in;
        end
    end

    assign flags_out = flags_q;
endmodule

// [rtl/rsim_regs.sv]
// Regulator status registers, top-level interrupt mask registers and event flags.
// Assumes a byte register port from the serial interface logic and live levels synchronous to sys_clk_in.
`timescale 1ns/10ps
module rsim_regs (
    input wire logic sys_clk_in, // System clock, 100 MHz.
    input wire logic srst_in, // Synchronous reset, active high.
    input wire rsim_pkg::rsim_bus_s reg_bus_in, // Register write and read strobes.
    output logic [7:0] reg_rdata_out, // Read data, registered.
    output logic reg_rvalid_out, // Read data valid, one cycle.
    input wire rsim_pkg::rsim_ldo_s linreg_a_in, // First linear regulator live state.
    input wire rsim_pkg::rsim_ldo_s linreg_b_in, // Second linear regulator live state.
    input wire rsim_pkg::rsim_top_s top_in, // Top-level live state.
    input wire logic load_meas_ready_in, // Measurement done pulse.
    output logic irq_req_out // Interrupt request, active high.
);

    logic [7:0] mask_pri_q;
    logic [7:0] mask_sec_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [7:0] linear_reg_status;
    logic [7:0] top_status;
    logic [7:0] flags;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [1:0] lvl;
    logic [1:0] lvl_rise;
    logic [1:0] lvl_fall;
    logic warn_lvl;
    logic warn_rise;
    logic wr_hit_mask;
    logic wr_hit_flags;

    always_comb begin
        linear_reg_status = 8'h00;
        linear_reg_status[rsim_pkg::LDO_B_ON] = linreg_b_in.enabled;
        linear_reg_status[rsim_pkg::LDO_B_VINV] = linreg_b_in.vout_invalid;
        linear_reg_status[rsim_pkg::LDO_B_ILIM] = linreg_b_in.current_limited;
        linear_reg_status[rsim_pkg::LDO_A_ON] = linreg_a_in.enabled;
        linear_reg_status[rsim_pkg::LDO_A_VINV] = linreg_a_in.vout_invalid;
        linear_reg_status[rsim_pkg::LDO_A_ILIM] = linreg_a_in.current_limited;
    end

    // The top status is built from live levels only, so no mask can reach it.
    // power good follows pin
    always_comb begin
        top_status = 8'h00;
        top_status[rsim_pkg::TOP_PG] = top_in.power_good_pin;
        top_status[rsim_pkg::TOP_SYNC] = top_in.ext_clk_invalid;
        top_status[rsim_pkg::TOP_TSD] = top_in.thermal_shutdown;
        top_status[rsim_pkg::TOP_TWARN] = top_in.thermal_warning;
        top_status[rsim_pkg::TOP_OVP] = top_in.input_ovp;
    end

    function automatic logic [7:0] read_mux(input logic [7:0] addr);
        logic [7:0] val;
        val = 8'h00;
        if (addr == rsim_pkg::ADDR_LINREG_STAT) begin
            val = linear_reg_status;
        end else if (addr == rsim_pkg::ADDR_TOP_STAT) begin
            val = top_status;
        end else if (addr == rsim_pkg::ADDR_MASK_PRI) begin
            val = mask_pri_q;
        end else if (addr == rsim_pkg::ADDR_MASK_SEC) begin
            val = mask_sec_q;
        end else if (addr == rsim_pkg::ADDR_IRQ_FLAGS) begin
            val = flags;
        end
        return val;
    endfunction

    assign wr_hit_mask = reg_bus_in.wr && (reg_bus_in.addr == rsim_pkg::ADDR_MASK_PRI);
    assign wr_hit_flags = reg_bus_in.wr && (reg_bus_in.addr == rsim_pkg::ADDR_IRQ_FLAGS);

    // mask register
    // Reserved bits are never stored, so they read 0 whatever is written.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mask_pri_q <= rsim_pkg::MASK_PRI_RST;
        end else if (wr_hit_mask) begin
            mask_pri_q <= reg_bus_in.data & rsim_pkg::MASK_PRI_WR;
        end
    end

    // The register reset mask is reloaded at reset only; host writes cannot change it.
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mask_sec_q <= rsim_pkg::MASK_SEC_RST;
        end else begin
            mask_sec_q <= mask_sec_q;
        end
    end

    // Read answer one cycle after the strobe; unmapped addresses read 0.
    // status writes ignored
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_bus_in.rd) begin
            rdata_q <= read_mux(reg_bus_in.addr);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_bus_in.rd;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;

    // Power good and clock validity report both directions of change.
    assign lvl = {top_in.power_good_pin, top_in.ext_clk_invalid};
    assign warn_lvl = top_in.thermal_warning;

    rsim_evt_detect #(
        .W(2)
    ) u_lvl_evt (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .level_in(lvl),
        .rise_out(lvl_rise),
        .fall_out(lvl_fall)
    );

    rsim_evt_detect #(
        .W(1)
    ) u_warn_evt (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .level_in(warn_lvl),
        .rise_out(warn_rise),
        .fall_out()
    );

    always_comb begin
        flag_set = 8'h00;
        flag_set[rsim_pkg::EVT_PG] = lvl_rise[1] | lvl_fall[1];
        flag_set[rsim_pkg::EVT_SYNC] = lvl_rise[0] | lvl_fall[0];
        flag_set[rsim_pkg::EVT_TWARN] = warn_rise;
        flag_set[rsim_pkg::EVT_MEAS] = load_meas_ready_in;
    end

    assign flag_clr = wr_hit_flags ? (reg_bus_in.data & rsim_pkg::FLAG_BITS) : 8'h00;

    rsim_flag_bank #(
        .W(8)
    ) u_flags (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .flags_out(flags)
    );

    assign irq_req_out = |(flags & ~mask_pri_q & rsim_pkg::FLAG_BITS);

    logic rd_ldo;
    logic rd_top;
    logic rd_mask;
    assign rd_ldo = reg_bus_in.rd && (reg_bus_in.addr == rsim_pkg::ADDR_LINREG_STAT);
    assign rd_top = reg_bus_in.rd && (reg_bus_in.addr == rsim_pkg::ADDR_TOP_STAT);
    assign rd_mask = reg_bus_in.rd && (reg_bus_in.addr == rsim_pkg::ADDR_MASK_PRI);

    b_enable_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo |=> reg_rdata_out[7] == $past(linreg_b_in.enabled))
        else $error("second regulator enable bit wrong");

    a_enable_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo |=> reg_rdata_out[3] == $past(linreg_a_in.enabled))
        else $error("first regulator enable bit wrong");

    b_vout_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo |=> reg_rvalid_out && reg_rdata_out[6] == $past(linreg_b_in.vout_invalid))
        else $error("second regulator validity bit wrong");

    a_vout_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo |=> reg_rdata_out[2] == $past(linreg_a_in.vout_invalid))
        else $error("first regulator validity bit wrong");

    b_ilim_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo |=> reg_rdata_out[4] == $past(linreg_b_in.current_limited))
        else $error("second regulator limit bit wrong");

    a_ilim_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo |=> reg_rdata_out[0] == $past(linreg_a_in.current_limited))
        else $error("first regulator limit bit wrong");

    mask_reset_a: assert property (@(posedge sys_clk_in)
        srst_in |=> mask_pri_q[7] && mask_pri_q[4] && mask_pri_q[0] && !mask_pri_q[2])
        else $error("mask reset value wrong");

    pg_live_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_top |=> reg_rdata_out[7] == $past(top_in.power_good_pin))
        else $error("power good status not following pin");

    sync_live_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_top |=> reg_rdata_out[4] == $past(top_in.ext_clk_invalid))
        else $error("clock status affected by mask");

    warn_live_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_top |=> reg_rdata_out[2] == $past(top_in.thermal_warning))
        else $error("thermal status affected by mask");

    flag_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        flags[0] && !(wr_hit_flags && reg_bus_in.data[0]) |=> flags[0])
        else $error("flag lost without clear");

    flag_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_hit_flags && reg_bus_in.data[0] && !load_meas_ready_in |=> !flags[0])
        else $error("flag not cleared by write of one");

    meas_set_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        load_meas_ready_in && mask_pri_q[0] |=> flags[rsim_pkg::EVT_MEAS])
        else $error("masked event did not latch");

    irq_gate_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        (mask_pri_q == 8'h95) |-> !irq_req_out)
        else $error("request raised while fully masked");

    rsvd_zero_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_mask |=> (reg_rdata_out & 8'h6A) == 8'h00)
        else $error("reserved mask bits not zero");

    irq_raise_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        ((flags[rsim_pkg::EVT_PG] && !mask_pri_q[rsim_pkg::EVT_PG]) ||
        (flags[rsim_pkg::EVT_SYNC] && !mask_pri_q[rsim_pkg::EVT_SYNC]) ||
        (flags[rsim_pkg::EVT_TWARN] && !mask_pri_q[rsim_pkg::EVT_TWARN]) ||
        (flags[rsim_pkg::EVT_MEAS] && !mask_pri_q[rsim_pkg::EVT_MEAS])) |-> irq_req_out)
        else $error("unmasked flag raised no request");

    // The history check keeps the first cycle after reset out, where no event may be reported.
    pg_event_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !$past(srst_in) && (top_in.power_good_pin != $past(top_in.power_good_pin)) |=> flags[rsim_pkg::EVT_PG])
        else $error("power good change did not latch");

    pg_clear_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_hit_flags && reg_bus_in.data[rsim_pkg::EVT_PG] && !flag_set[rsim_pkg::EVT_PG]
            |=> !flags[rsim_pkg::EVT_PG])
        else $error("power good flag not cleared by write of one");

    pg_mask_wr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_hit_mask |=> mask_pri_q[rsim_pkg::EVT_PG] == $past(reg_bus_in.data[rsim_pkg::EVT_PG]))
        else $error("power good mask bit not written");

    sync_mask_wr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_hit_mask |=> mask_pri_q[rsim_pkg::EVT_SYNC] == $past(reg_bus_in.data[rsim_pkg::EVT_SYNC]))
        else $error("clock mask bit not written");

    warn_mask_wr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_hit_mask |=> mask_pri_q[rsim_pkg::EVT_TWARN] == $past(reg_bus_in.data[rsim_pkg::EVT_TWARN]))
        else $error("thermal mask bit not written");

    meas_mask_wr_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        wr_hit_mask |=> mask_pri_q[rsim_pkg::EVT_MEAS] == $past(reg_bus_in.data[rsim_pkg::EVT_MEAS]))
        else $error("measurement mask bit not written");

    sec_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        reg_bus_in.rd && (reg_bus_in.addr == rsim_pkg::ADDR_MASK_SEC) |=> reg_rdata_out[7:1] == 7'h00)
        else $error("reserved secondary mask bits not zero");

    pg_mask_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        flags[7] && !mask_pri_q[7] && irq_req_out);

    clear_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        flags[2] ##1 wr_hit_flags && reg_bus_in.data[2] ##1 !flags[2]);

    ldo_read_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        rd_ldo && linreg_b_in.enabled && linreg_a_in.current_limited);

    meas_irq_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        flags[rsim_pkg::EVT_MEAS] && !mask_pri_q[rsim_pkg::EVT_MEAS] && irq_req_out);

    meas_masked_c: cover property (@(posedge sys_clk_in) disable iff (srst_in)
        flags[rsim_pkg::EVT_MEAS] && mask_pri_q[rsim_pkg::EVT_MEAS] && !irq_req_out);

endmodule

// [test/rsim_host_model.sv]
// Host side model of the register port, standing in for the serial interface logic.
// Assumes the bench calls its tasks by hierarchical name, one request at a time.
`timescale 1ns/10ps
module rsim_host_model (
    input wire logic sys_clk_in, // System clock.
    output rsim_pkg::rsim_bus_s bus_out, // Register requests to the block.
    input wire logic [7:0] rdata_in, // Read data from the block.
    input wire logic rvalid_in // Read data valid from the block.
);
    initial begin
        bus_out = '0;
    end

    // Released address and data are inverted so that a stale value never passes for a live one.
    task automatic release_bus();
        bus_out.wr <= 1'b0;
        bus_out.rd <= 1'b0;
        bus_out.addr <= ~bus_out.addr;
        bus_out.data <= ~bus_out.data;
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk_in);
        bus_out.wr <= 1'b1;
        bus_out.addr <= addr;
        bus_out.data <= data;
        @(posedge sys_clk_in);
        release_bus();
    endtask

    // The answer is registered at the taking edge, so it is read once that edge has settled.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge sys_clk_in);
        bus_out.rd <= 1'b1;
        bus_out.addr <= addr;
        @(posedge sys_clk_in);
        release_bus();
        #1;
        ok = rvalid_in;
        data = rdata_in;
    endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the regulator status and interrupt mask registers.
// Assumes the host model drives the register port and the bench drives the live state inputs.
`timescale 1ns/10ps
module testbench;
    logic sys_clk_in;
    logic srst_in;
    rsim_pkg::rsim_bus_s reg_bus;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    rsim_pkg::rsim_ldo_s linreg_a;
    rsim_pkg::rsim_ldo_s linreg_b;
    rsim_pkg::rsim_top_s top;
    logic load_meas_ready;
    logic irq_req;
    int n_mismatch;
    int checks_done;

    rsim_regs dut (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .reg_bus_in(reg_bus),
        .reg_rdata_out(reg_rdata),
        .reg_rvalid_out(reg_rvalid),
        .linreg_a_in(linreg_a),
        .linreg_b_in(linreg_b),
        .top_in(top),
        .load_meas_ready_in(load_meas_ready),
        .irq_req_out(irq_req)
    );

    rsim_host_model host (
        .sys_clk_in(sys_clk_in),
        .bus_out(reg_bus),
        .rdata_in(reg_rdata),
        .rvalid_in(reg_rvalid)
    );

    always #5 sys_clk_in = ~sys_clk_in;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic rd_expect(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host.read_reg(addr, d, ok);
        check({name, " valid"}, {7'h00, ok}, 8'h01);
        check(name, d, exp);
    endtask

    function automatic logic [7:0] top_exp();
        return {top.power_good_pin, 2'b00, top.ext_clk_invalid, top.thermal_shutdown,
                top.thermal_warning, top.input_ovp, 1'b0};
    endfunction

    task automatic reset_values();
        rd_expect("mask primary", rsim_pkg::ADDR_MASK_PRI, 8'h91);
        rd_expect("mask secondary", rsim_pkg::ADDR_MASK_SEC, 8'h01);
        rd_expect("linreg status", rsim_pkg::ADDR_LINREG_STAT, 8'h00);
        rd_expect("flags", rsim_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd_expect("unmapped", 8'h7E, 8'h00);
        check("irq at reset", {7'h00, irq_req}, 8'h00);
    endtask

    task automatic status_bits();
        logic [7:0] exp;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_in);
            linreg_a <= i[2:0];
            linreg_b <= ~i[2:0];
            top.thermal_shutdown <= i[0];
            top.input_ovp <= i[1];
            tick(1);
            exp = {linreg_b.enabled, linreg_b.vout_invalid, 1'b0, linreg_b.current_limited,
                   linreg_a.enabled, linreg_a.vout_invalid, 1'b0, linreg_a.current_limited};
            rd_expect("linreg status", rsim_pkg::ADDR_LINREG_STAT, exp);
            rd_expect("top status", rsim_pkg::ADDR_TOP_STAT, top_exp());
        end
        host.write_reg(rsim_pkg::ADDR_LINREG_STAT, ~exp);
        rd_expect("status after write", rsim_pkg::ADDR_LINREG_STAT, exp);
    endtask

    task automatic mask_write();
        host.write_reg(rsim_pkg::ADDR_MASK_PRI, 8'hFF);
        rd_expect("mask all ones", rsim_pkg::ADDR_MASK_PRI, 8'h95);
        host.write_reg(rsim_pkg::ADDR_MASK_PRI, 8'h00);
        rd_expect("mask all zeros", rsim_pkg::ADDR_MASK_PRI, 8'h00);
    endtask

    // Each event is raised while masked, then unmasked, then cleared by writing one.
    task automatic event_masks();
        int pos[4];
        logic [7:0] bit8;
        pos = '{rsim_pkg::EVT_PG, rsim_pkg::EVT_SYNC, rsim_pkg::EVT_TWARN, rsim_pkg::EVT_MEAS};
        for (int k = 0; k < 4; k++) begin
            bit8 = 8'h01 << pos[k];
            host.write_reg(rsim_pkg::ADDR_MASK_PRI, 8'hFF);
            @(posedge sys_clk_in);
            case (k)
                0: top.power_good_pin <= ~top.power_good_pin;
                1: top.ext_clk_invalid <= ~top.ext_clk_invalid;
                2: top.thermal_warning <= 1'b1;
                default: load_meas_ready <= 1'b1;
            endcase
            @(posedge sys_clk_in);
            load_meas_ready <= 1'b0;
            tick(2);
            rd_expect("flag while masked", rsim_pkg::ADDR_IRQ_FLAGS, bit8);
            check("irq while masked", {7'h00, irq_req}, 8'h00);
            rd_expect("live status masked", rsim_pkg::ADDR_TOP_STAT, top_exp());
            host.write_reg(rsim_pkg::ADDR_MASK_PRI, 8'h95 & ~bit8);
            tick(1);
            check("irq unmasked", {7'h00, irq_req}, 8'h01);
            host.write_reg(rsim_pkg::ADDR_IRQ_FLAGS, 8'h00);
            rd_expect("flag after zero write", rsim_pkg::ADDR_IRQ_FLAGS, bit8);
            host.write_reg(rsim_pkg::ADDR_IRQ_FLAGS, bit8);
            rd_expect("flag after clear", rsim_pkg::ADDR_IRQ_FLAGS, 8'h00);
            check("irq after clear", {7'h00, irq_req}, 8'h00);
        end
    endtask

    // A mid-run reset with a flag set and levels high must clear the flag and raise no false event.
    task automatic reset_again();
        @(posedge sys_clk_in);
        load_meas_ready <= 1'b1;
        @(posedge sys_clk_in);
        load_meas_ready <= 1'b0;
        srst_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        tick(2);
        rd_expect("flags after reset", rsim_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd_expect("mask after reset", rsim_pkg::ADDR_MASK_PRI, 8'h91);
        check("irq after reset", {7'h00, irq_req}, 8'h00);
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk_in = 1'b0;
        srst_in = 1'b1;
        linreg_a = '0;
        linreg_b = '0;
        top = '0;
        load_meas_ready = 1'b0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (4) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        reset_values();
        status_bits();
        mask_write();
        event_masks();
        reset_again();
        stop_test();
    end

    // The whole run takes well under a thousand cycles; this limit is ten times that.
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule
